// ==== verilog/urxb_pkg.sv ====
// Shared constants and types for the receive buffer and its software-side controller
package urxb_pkg;
    // Device register port addresses
    localparam logic [1:0] URXB_ADDR_STATUS = 2'h0;
    localparam logic [1:0] URXB_ADDR_CONTROL = 2'h1;
    localparam logic [1:0] URXB_ADDR_FORMAT = 2'h2;
    localparam logic [1:0] URXB_ADDR_DATA = 2'h3;
    // Status register bits
    localparam int URXB_ST_RXC = 7;
    localparam int URXB_ST_FE = 4;
    localparam int URXB_ST_DOR = 3;
    localparam int URXB_ST_PE = 2;
    localparam logic [7:0] URXB_ST_ERR_MASK = 8'h1c;
    // Control register bits
    localparam int URXB_CT_RECEIVE_COMPLETE_IRQ_ENABLE = 7;
    localparam int URXB_CT_RECEIVER_ENABLE = 4;
    localparam int URXB_CT_RECEIVED_NINTH_BIT = 1;
    localparam int URXB_CT_TRANSMIT_NINTH_BIT = 0;
    localparam logic [7:0] URXB_CT_WR_MASK = 8'h91;
    // Frame format register fields
    localparam int URXB_FM_PAR_EN = 5;
    localparam int URXB_FM_PAR_ODD = 4;
    localparam int URXB_FM_STOP2 = 3;
    localparam logic [2:0] URXB_SIZE_NINE = 3'h7;
    localparam logic [3:0] URXB_SIZE_BASE = 4'h5;
    localparam logic [3:0] URXB_NINE_BITS = 4'h9;
    localparam logic [7:0] URXB_CTL_RESET = 8'h00;
    localparam logic [7:0] URXB_FMT_RESET = 8'h06;
    // Receive buffer and bit timing defaults
    localparam int URXB_FIFO_DEPTH = 2;
    localparam int URXB_BAUD_W = 16;
    localparam int URXB_CYCLES_PER_BIT = 16;
    // Controller APB register offsets
    localparam logic [7:0] URXB_APB_CONFIG = 8'h00;
    localparam logic [7:0] URXB_APB_COMMAND = 8'h04;
    localparam logic [7:0] URXB_APB_STATE = 8'h08;
    localparam logic [7:0] URXB_APB_CHAR = 8'h0c;
    localparam int URXB_CMD_FETCH = 0;
    localparam int URXB_CMD_FLUSH = 1;
    localparam int URXB_CMD_CONFIG = 2;

    // One stored character with its flags
    typedef struct packed {
        logic [8:0] data;
        logic       fe;
        logic       overrun_flag;
        logic       pe;
    } urxb_entry_type;

    typedef enum logic [2:0] {
        URXB_RX_IDLE   = 3'b000,
        URXB_RX_START  = 3'b001,
        URXB_RX_DATA   = 3'b010,
        URXB_RX_PARITY = 3'b011,
        URXB_RX_STOP   = 3'b100
    } urxb_rx_state_type;
endpackage

// ==== verilog/urxb_reg_if.sv ====
// Register port between the receive buffer and its software-side controller
`timescale 1ns/10ps
`default_nettype none
interface urxb_reg_if;
    logic [1:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       rvalid;

    modport dev (
        input  addr,
        input  rd,
        input  wr,
        input  wdata,
        output rdata,
        output rvalid
    );
    modport sw (
        output addr,
        output rd,
        output wr,
        output wdata,
        input  rdata,
        input  rvalid
    );
endinterface
`default_nettype wire

// ==== verilog/urxb_receiver.sv ====
// Serial receiver with two-entry receive buffer, status and control registers
//
// Chosen here: the register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module urxb_receiver
    import urxb_pkg::*;
#(
    parameter int FIFO_DEPTH     = URXB_FIFO_DEPTH,
    parameter int CYCLES_PER_BIT = URXB_CYCLES_PER_BIT
) (
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    urxb_reg_if.dev   regs,
    input  wire logic rxd_i,
    input  wire logic global_irq_enable_i,
    output logic      rx_irq_request_o,
    output logic      rx_pin_owned_o
);
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(FIFO_DEPTH);
    localparam logic [URXB_BAUD_W-1:0] BIT_RELOAD = URXB_BAUD_W'(CYCLES_PER_BIT - 1);
    localparam logic [URXB_BAUD_W-1:0] HALF_RELOAD = URXB_BAUD_W'(CYCLES_PER_BIT / 2 - 1);

    typedef struct packed {
        urxb_rx_state_type               st;
        logic [URXB_BAUD_W-1:0]          baud;
        logic [3:0]                      bit_idx;
        logic [3:0]                      nbits;
        logic [8:0]                      shift;
        logic                            par_en;
        logic                            par_odd;
        logic                            par_err;
        logic                            hold_valid;
        urxb_entry_type                  hold;
        logic                            ovr_pend;
        urxb_entry_type [FIFO_DEPTH-1:0] fifo;
        logic [CNT_W-1:0]                count;
        logic [7:0]                      ctl;
        logic [7:0]                      fmt;
        logic [7:0]                      rdata;
        logic                            rvalid;
        logic                            irq;
        logic                            pin_own;
    } urxb_rx_regs_type;

    urxb_rx_regs_type r;
    urxb_rx_regs_type next_r;

    // Register port, receiver machine and buffer in one combinational pass
    always_comb begin
        logic           enabled;
        logic           popping;
        logic           tick;
        urxb_entry_type head;
        enabled = r.ctl[URXB_CT_RECEIVER_ENABLE];
        popping = 1'b0;
        tick = (r.baud == '0);
        head = r.fifo[0];
        next_r = r;
        next_r.rvalid = 1'b0;

        // Reads answer one cycle later from the pre-pop state
        if (regs.rd) begin
            next_r.rvalid = 1'b1;
            case (regs.addr)
                URXB_ADDR_STATUS: begin
                    next_r.rdata = 8'h00;
                    next_r.rdata[URXB_ST_RXC] = (r.count != '0);
                    next_r.rdata[URXB_ST_FE] = (r.count != '0) & head.fe;
                    next_r.rdata[URXB_ST_DOR] = (r.count != '0) & head.overrun_flag;
                    next_r.rdata[URXB_ST_PE] = (r.count != '0) & head.pe;
                end
                URXB_ADDR_CONTROL: begin
                    next_r.rdata = r.ctl & URXB_CT_WR_MASK;
                    next_r.rdata[URXB_CT_RECEIVED_NINTH_BIT] = (r.count != '0) & head.data[8];
                end
                URXB_ADDR_FORMAT: begin
                    next_r.rdata = r.fmt;
                end
                URXB_ADDR_DATA: begin
                    next_r.rdata = head.data[7:0];
                    popping = (r.count != '0);
                end
                default: begin
                    next_r.rdata = 8'h00;
                end
            endcase
        end

        // Data read advances the buffer
        if (popping) begin
            for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                next_r.fifo[i] = r.fifo[i + 1];
            end
            next_r.fifo[FIFO_DEPTH-1] = '0;
            next_r.count = r.count - CNT_W'(1);
        end

        // Waiting frame enters the buffer once there is room
        if (r.hold_valid && (next_r.count != FULL_COUNT)) begin
            next_r.fifo[next_r.count] = r.hold;
            next_r.fifo[next_r.count].overrun_flag = r.ovr_pend;
            next_r.ovr_pend = 1'b0;
            next_r.hold_valid = 1'b0;
            next_r.count = next_r.count + CNT_W'(1);
        end

        // Status writes have no writable bits, so error flags stay put
        if (regs.wr) begin
            case (regs.addr)
                URXB_ADDR_CONTROL: next_r.ctl = regs.wdata & URXB_CT_WR_MASK;
                URXB_ADDR_FORMAT: next_r.fmt = regs.wdata;
                default: next_r.ctl = next_r.ctl;
            endcase
        end

        // Bit timing counts down while a frame is in progress
        if (r.st != URXB_RX_IDLE) begin
            next_r.baud = tick ? BIT_RELOAD : r.baud - URXB_BAUD_W'(1);
        end

        case (r.st)
            URXB_RX_IDLE: begin
                if (enabled && !rxd_i) begin
                    // Frame settings are latched so mid-frame writes cannot tear it
                    next_r.st = URXB_RX_START;
                    next_r.baud = HALF_RELOAD;
                    next_r.bit_idx = 4'h0;
                    next_r.shift = 9'h000;
                    next_r.par_en = r.fmt[URXB_FM_PAR_EN];
                    next_r.par_odd = r.fmt[URXB_FM_PAR_ODD];
                    next_r.nbits = (r.fmt[2:0] == URXB_SIZE_NINE) ? URXB_NINE_BITS
                                 : URXB_SIZE_BASE + {2'b00, r.fmt[1:0]};
                    // Buffer full and a frame still waiting: that frame is lost
                    if (next_r.hold_valid && (next_r.count == FULL_COUNT)) begin
                        next_r.ovr_pend = 1'b1;
                        next_r.hold_valid = 1'b0;
                    end
                end
            end
            URXB_RX_START: begin
                if (tick) begin
                    // Line back high at mid start bit is taken as a glitch
                    next_r.st = rxd_i ? URXB_RX_IDLE : URXB_RX_DATA;
                end
            end
            URXB_RX_DATA: begin
                if (tick) begin
                    next_r.shift[r.bit_idx] = rxd_i;
                    next_r.bit_idx = r.bit_idx + 4'h1;
                    if (r.bit_idx + 4'h1 == r.nbits) begin
                        next_r.st = r.par_en ? URXB_RX_PARITY : URXB_RX_STOP;
                    end
                end
            end
            URXB_RX_PARITY: begin
                if (tick) begin
                    next_r.par_err = (^r.shift) ^ rxd_i ^ r.par_odd;
                    next_r.st = URXB_RX_STOP;
                end
            end
            URXB_RX_STOP: begin
                if (tick) begin
                    // Only the first stop bit is sampled; a second one is idle line
                    next_r.st = URXB_RX_IDLE;
                    next_r.hold_valid = 1'b1;
                    next_r.hold.data = r.shift;
                    next_r.hold.fe = ~rxd_i;
                    next_r.hold.overrun_flag = 1'b0;
                    next_r.hold.pe = r.par_en & r.par_err;
                    next_r.par_err = 1'b0;
                end
            end
            default: begin
                next_r.st = URXB_RX_IDLE;
            end
        endcase

        // Disable acts at once: frame in progress and buffer are discarded
        if (!next_r.ctl[URXB_CT_RECEIVER_ENABLE]) begin
            next_r.st = URXB_RX_IDLE;
            next_r.count = '0;
            next_r.fifo = '0;
            next_r.hold_valid = 1'b0;
            next_r.ovr_pend = 1'b0;
            next_r.par_err = 1'b0;
        end

        next_r.pin_own = next_r.ctl[URXB_CT_RECEIVER_ENABLE];
        // Only the complete flag requests service, never the error flags
        next_r.irq = (next_r.count != '0) & next_r.ctl[URXB_CT_RECEIVE_COMPLETE_IRQ_ENABLE] & global_irq_enable_i;
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '{st: URXB_RX_IDLE, ctl: URXB_CTL_RESET, fmt: URXB_FMT_RESET, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign regs.rdata = r.rdata;
    assign regs.rvalid = r.rvalid;
    assign rx_irq_request_o = r.irq;
    assign rx_pin_owned_o = r.pin_own;
endmodule
`default_nettype wire

// ==== verilog/urxb_controller.sv ====
// Software-side controller: APB registers, ordered accesses to the receive buffer
`timescale 1ns/10ps
`default_nettype none
module urxb_controller
    import urxb_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    urxb_reg_if.sw           regs
);
    typedef enum logic [3:0] {
        URXB_C_IDLE   = 4'b0000,
        URXB_C_WSTAT  = 4'b0001,
        URXB_C_WCTL   = 4'b0010,
        URXB_C_WFMT   = 4'b0011,
        URXB_C_RSTAT  = 4'b0100,
        URXB_C_RSTATW = 4'b0101,
        URXB_C_RCTL   = 4'b0110,
        URXB_C_RCTLW  = 4'b0111,
        URXB_C_RDATA  = 4'b1000,
        URXB_C_RDATAW = 4'b1001
    } urxb_ctl_state_type;

    typedef struct packed {
        urxb_ctl_state_type st;
        logic               flushing;
        logic [15:0]        config_word;
        logic [7:0]         status;
        logic [7:0]         control;
        logic [11:0]        chr;
        logic               chr_valid;
        logic [1:0]         addr;
        logic               rd;
        logic               wr;
        logic [7:0]         wdata;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
    } urxb_ctl_regs_type;

    urxb_ctl_regs_type r;
    urxb_ctl_regs_type next_r;

    always_comb begin
        logic setup;
        logic access;
        logic busy;
        setup = psel_i & ~penable_i;
        access = psel_i & penable_i & r.pready;
        busy = (r.st != URXB_C_IDLE);
        next_r = r;
        next_r.rd = 1'b0;
        next_r.wr = 1'b0;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;

        // APB slave: answer in the cycle after setup
        if (setup) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
            case (paddr_i)
                URXB_APB_CONFIG: next_r.prdata = {16'h0000, r.config_word};
                URXB_APB_COMMAND: next_r.prdata = 32'h0000_0000;
                URXB_APB_STATE: next_r.prdata = {16'h0000, r.status, 6'h00, r.chr_valid, busy};
                URXB_APB_CHAR: next_r.prdata = {20'h00000, r.chr};
                default: next_r.pslverr = 1'b1;
            endcase
        end

        // Effects land only at the edge where the master sees pready
        if (access) begin
            if (pwrite_i && paddr_i == URXB_APB_CONFIG) begin
                next_r.config_word = pwdata_i[15:0];
            end
            // Commands arriving while busy are dropped
            if (pwrite_i && paddr_i == URXB_APB_COMMAND && !busy) begin
                if (pwdata_i[URXB_CMD_CONFIG]) begin
                    next_r.st = URXB_C_WSTAT;
                end else if (pwdata_i[URXB_CMD_FETCH] || pwdata_i[URXB_CMD_FLUSH]) begin
                    next_r.st = URXB_C_RSTAT;
                    next_r.flushing = pwdata_i[URXB_CMD_FLUSH];
                    next_r.chr_valid = 1'b0;
                end
            end
            if (!pwrite_i && paddr_i == URXB_APB_CHAR) begin
                next_r.chr_valid = 1'b0;
            end
        end

        // Device access sequencer
        case (r.st)
            URXB_C_IDLE: begin
                next_r.st = next_r.st;
            end
            URXB_C_WSTAT: begin
                next_r.wr = 1'b1;
                next_r.addr = URXB_ADDR_STATUS;
                next_r.wdata = 8'h00 & ~URXB_ST_ERR_MASK;
                next_r.st = URXB_C_WCTL;
            end
            URXB_C_WCTL: begin
                next_r.wr = 1'b1;
                next_r.addr = URXB_ADDR_CONTROL;
                next_r.wdata = r.config_word[7:0];
                next_r.st = URXB_C_WFMT;
            end
            URXB_C_WFMT: begin
                next_r.wr = 1'b1;
                next_r.addr = URXB_ADDR_FORMAT;
                next_r.wdata = r.config_word[15:8];
                next_r.st = URXB_C_IDLE;
            end
            // Status first, since the data read moves the flags on
            URXB_C_RSTAT: begin
                next_r.rd = 1'b1;
                next_r.addr = URXB_ADDR_STATUS;
                next_r.st = URXB_C_RSTATW;
            end
            URXB_C_RSTATW: begin
                if (regs.rvalid) begin
                    next_r.status = regs.rdata;
                    // Nothing waiting ends both fetch and flush
                    next_r.st = regs.rdata[URXB_ST_RXC] ? URXB_C_RCTL : URXB_C_IDLE;
                end
            end
            URXB_C_RCTL: begin
                next_r.rd = 1'b1;
                next_r.addr = URXB_ADDR_CONTROL;
                next_r.st = URXB_C_RCTLW;
            end
            URXB_C_RCTLW: begin
                if (regs.rvalid) begin
                    next_r.control = regs.rdata;
                    next_r.st = URXB_C_RDATA;
                end
            end
            URXB_C_RDATA: begin
                next_r.rd = 1'b1;
                next_r.addr = URXB_ADDR_DATA;
                next_r.st = URXB_C_RDATAW;
            end
            URXB_C_RDATAW: begin
                if (regs.rvalid) begin
                    next_r.chr = {r.status[URXB_ST_PE], r.status[URXB_ST_DOR], r.status[URXB_ST_FE],
                                  r.control[URXB_CT_RECEIVED_NINTH_BIT], regs.rdata};
                    next_r.chr_valid = ~r.flushing;
                    // Flush keeps reading until the complete flag is clear
                    next_r.st = r.flushing ? URXB_C_RSTAT : URXB_C_IDLE;
                end
            end
            default: begin
                next_r.st = URXB_C_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '{st: URXB_C_IDLE, config_word: {URXB_FMT_RESET, URXB_CTL_RESET}, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign prdata_o = r.prdata;
    assign pready_o = r.pready;
    assign pslverr_o = r.pslverr;
    assign regs.addr = r.addr;
    assign regs.rd = r.rd;
    assign regs.wr = r.wr;
    assign regs.wdata = r.wdata;
endmodule
`default_nettype wire

// ==== sim/urxb_properties.sv ====
// Assertions on the register port and the receive status outputs
`timescale 1ns/10ps
`default_nettype none
module urxb_properties
    import urxb_pkg::*;
(
    input wire logic       ref_clk_i,
    input wire logic       reset_n_i,
    input wire logic [1:0] addr,
    input wire logic       rd,
    input wire logic       wr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       rvalid,
    input wire logic       global_irq_enable_i,
    input wire logic       rx_irq_request_o,
    input wire logic       rx_pin_owned_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    logic [1:0] rd_addr;
    logic       ie;
    logic       off;
    logic       st_rsp;
    // Shadows; off starts set because control resets to zero
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_addr <= 2'h0;
            ie      <= 1'b0;
            off     <= 1'b1;
        end else begin
            if (rd) begin
                rd_addr <= addr;
            end
            if (wr && addr == URXB_ADDR_CONTROL) begin
                ie  <= wdata[URXB_CT_RECEIVE_COMPLETE_IRQ_ENABLE];
                off <= !wdata[URXB_CT_RECEIVER_ENABLE];
            end
        end
    end
    // Answer to a status read
    assign st_rsp = rvalid && rd_addr == URXB_ADDR_STATUS;
    a_read_answer: assert property (rd |=> rvalid)
        else $error("read strobe got no answer");
    a_no_stray_answer: assert property (!rd |=> !rvalid)
        else $error("answer without read strobe");
    a_pin_follows_enable: assert property (rx_pin_owned_o == !off)
        else $error("pin ownership does not follow enable");
    a_irq_needs_global: assert property (rx_irq_request_o |-> $past(global_irq_enable_i))
        else $error("request without global enable");
    a_irq_needs_enable: assert property (rx_irq_request_o |-> ie)
        else $error("request without receive enable bit");
    a_irq_while_full: assert property (st_rsp && rdata[URXB_ST_RXC] && $past(ie)
        && $past(global_irq_enable_i) |-> rx_irq_request_o)
        else $error("no request while data waits");
    a_irq_quiet_empty: assert property (st_rsp && !rdata[URXB_ST_RXC] |-> !$past(rx_irq_request_o))
        else $error("request with empty buffer");
    a_disabled_empty: assert property (st_rsp && $past(off, 3) && $past(off)
        |-> !rdata[URXB_ST_RXC])
        else $error("data left after disable");
    a_status_wr_zero: assert property (wr && addr == URXB_ADDR_STATUS |-> (wdata & URXB_ST_ERR_MASK) == 8'h00)
        else $error("error bits written as one");
    c_frame_error: cover property (st_rsp && rdata[URXB_ST_FE]);
    c_overrun: cover property (st_rsp && rdata[URXB_ST_DOR]);
    c_irq: cover property (rx_irq_request_o);
endmodule
`default_nettype wire

// ==== sim/uart_receive_buffer_status_test.sv ====
// Bench: controller and receiver joined, driven over APB and the serial line
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin miscompares++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module uart_receive_buffer_status_test
    import urxb_pkg::*;
;
    localparam int CPB = 4;
    logic        ref_clk_i;
    logic        reset_n_i = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic        prdy;
    logic        perr;
    logic        rxd = 1'b1;
    logic        gie = 1'b1;
    logic        irq;
    logic        pin;
    logic        last_err;
    int          miscompares = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [7:0]  st;
    logic [11:0] ch;
    logic [31:0] r;
    urxb_reg_if link ();
    urxb_controller i_urxb_controller (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .regs(link));
    urxb_receiver #(.CYCLES_PER_BIT(CPB)) i_urxb_receiver (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .regs(link), .rxd_i(rxd), .global_irq_enable_i(gie), .rx_irq_request_o(irq), .rx_pin_owned_o(pin));
    urxb_properties i_props (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .addr(link.addr), .rd(link.rd),
        .wr(link.wr), .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid),
        .global_irq_enable_i(gie), .rx_irq_request_o(irq), .rx_pin_owned_o(pin));
    // Clock
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Hang guard, well above the fewer than two thousand cycles the run needs
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // One APB transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        @(posedge ref_clk_i);
        pen <= 1'b1;
        do @(posedge ref_clk_i); while (prdy !== 1'b1);
        q = prd;
        last_err = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    // Poll until the controller is no longer busy
    task automatic wait_idle(output logic [31:0] q);
        int k;
        k = 0;
        do begin
            apb(1'b0, URXB_APB_STATE, 32'h0, q);
            k++;
        end while (q[0] !== 1'b0 && k < 40);
        `CHK("idle", 1'b0, q[0])
    endtask
    task automatic cfg(input logic [7:0] ctl, input logic [7:0] fmt);
        apb(1'b1, URXB_APB_CONFIG, {16'h0, fmt, ctl}, r);
        apb(1'b1, URXB_APB_COMMAND, 32'h4, r);
        wait_idle(r);
        repeat (4) @(posedge ref_clk_i);
    endtask
    task automatic fetch();
        apb(1'b1, URXB_APB_COMMAND, 32'h1, r);
        wait_idle(r);
        st = r[15:8];
        apb(1'b0, URXB_APB_CHAR, 32'h0, r);
        ch = r[11:0];
    endtask
    // Start bit, then n bits LSB first, then idle high
    task automatic ser(input logic [10:0] b, input int n);
        rxd <= 1'b0;
        repeat (CPB) @(posedge ref_clk_i);
        for (int i = 0; i < n; i++) begin
            rxd <= b[i];
            repeat (CPB) @(posedge ref_clk_i);
        end
        rxd <= 1'b1;
        repeat (2 * CPB) @(posedge ref_clk_i);
    endtask
    task automatic t_basic();
        cfg(8'h90, 8'h0b);
        `CHK("pin", 1'b1, pin)
        ser({3'b111, 8'h35}, 9);
        ser({3'b110, 8'ha6}, 9);
        `CHK("irq on", 1'b1, irq)
        gie <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        `CHK("irq gated", 1'b0, irq)
        gie <= 1'b1;
        cfg(8'h90, 8'h0b);
        fetch();
        `CHK("char1", 12'h035, ch)
        fetch();
        `CHK("char2", 12'h2a6, ch)
        `CHK("fe", 1'b1, st[URXB_ST_FE])
        fetch();
        `CHK("empty", 1'b0, st[URXB_ST_RXC])
        `CHK("irq off", 1'b0, irq)
        $display("t_basic done");
    endtask
    task automatic t_parity();
        logic p;
        for (int m = 0; m < 2; m++) begin
            cfg(8'h10, m[0] ? 8'h33 : 8'h23);
            p = (^8'h5b) ^ m[0];
            ser({2'b11, p, 8'h5b}, 10);
            ser({2'b11, ~p, 8'h5b}, 10);
            fetch();
            `CHK("par ok", 12'h05b, ch)
            fetch();
            `CHK("par bad", 12'h85b, ch)
        end
        cfg(8'h10, 8'h13);
        ser({3'b111, 8'h5a}, 9);
        fetch();
        `CHK("par off", 12'h05a, ch)
        $display("t_parity done");
    endtask
    task automatic t_overrun();
        cfg(8'h10, 8'h03);
        for (int i = 0; i < 4; i++) begin
            ser({3'b111, 8'h41 + 8'(i)}, 9);
        end
        `CHK("irq masked", 1'b0, irq)
        fetch();
        `CHK("ovr1", 12'h041, ch)
        fetch();
        `CHK("ovr2", 12'h042, ch)
        fetch();
        `CHK("ovr lost", 12'h444, ch)
        ser({3'b111, 8'h45}, 9);
        fetch();
        `CHK("ovr clear", 12'h045, ch)
        $display("t_overrun done");
    endtask
    task automatic t_flush();
        cfg(8'h10, 8'h07);
        ser({2'b11, 9'h1a5}, 10);
        fetch();
        `CHK("nine", 12'h1a5, ch)
        ser({3'b111, 8'h11}, 9);
        ser({3'b111, 8'h22}, 9);
        apb(1'b1, URXB_APB_COMMAND, 32'h2, r);
        wait_idle(r);
        `CHK("flushed", 1'b0, r[8 + URXB_ST_RXC])
        ser({3'b111, 8'h33}, 9);
        // Disable in the middle of a frame
        rxd <= 1'b0;
        repeat (3 * CPB) @(posedge ref_clk_i);
        cfg(8'h00, 8'h03);
        rxd <= 1'b1;
        `CHK("pin off", 1'b0, pin)
        fetch();
        `CHK("dis empty", 1'b0, st[URXB_ST_RXC])
        cfg(8'h10, 8'h03);
        repeat (12 * CPB) @(posedge ref_clk_i);
        fetch();
        `CHK("abandoned", 1'b0, st[URXB_ST_RXC])
        apb(1'b0, 8'h10, 32'h0, r);
        `CHK("unmapped", 1'b1, last_err)
        $display("t_flush done");
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        t_basic();
        t_parity();
        t_overrun();
        t_flush();
        report_and_stop();
    end
endmodule
`default_nettype wire
